// File: design/uef_pkg.sv
// Behaviour
// - Stuffing violation sets bit 7, packet rejected
// - Bad table or buffer address sets bit 6
// - Late grant or truncation sets bit 5
// - Over sixteen idle bit times sets bit 4
// - Partial-byte data field sets bit 3
// - Data CRC16 failure sets bit 2, rejected
// - Bit 1: host end-of-frame, device CRC5
// - Flags sticky, writing one clears them
// - Upper bits read zero, flags reset zero
// - Start-of-frame loads upper frame bits
package uef_pkg;

  // Avalon byte address width and register offsets
  localparam int UEF_AW = 4;
  localparam logic [UEF_AW-1:0] UEF_OFS_FLAGS = 4'h0;
  localparam logic [UEF_AW-1:0] UEF_OFS_MASK = 4'h4;
  localparam logic [UEF_AW-1:0] UEF_OFS_FRAME_NUMBER_UPPER_BITS = 4'h8;

  // Flag positions inside usb_error_flags
  localparam int UEF_B_STUFF = 7;
  localparam int UEF_B_BMX = 6;
  localparam int UEF_B_DMA = 5;
  localparam int UEF_B_BTO = 4;
  localparam int UEF_B_DFS = 3;
  localparam int UEF_B_CRC16 = 2;
  localparam int UEF_B_EOF = 1;
  localparam int UEF_B_PID = 0;

  // Reset values
  localparam logic [7:0] UEF_FLAGS_RST = 8'h00;
  localparam logic [7:0] UEF_MASK_RST = 8'h00;
  localparam logic [2:0] UEF_FRAME_NUMBER_UPPER_BITS_RST = 3'h0;

  // Turnaround limit, in bit times after end-of-packet
  localparam logic [4:0] UEF_TURN_BITS = 5'h10;

  // Fault and packet-end indications from the link engine
  typedef struct packed {
    logic stuff_err;
    logic bdt_base_bad;
    logic buf_addr_bad;
    logic grant_late;
    logic buf_trunc;
    logic rx_end;
    logic rx_data_pkt;
    logic crc16_bad;
    logic crc5_bad;
    logic [2:0] bit_resid;
    logic sof_zero;
    logic link_busy;
  } uef_evt_t;

  // State of the register and flag logic
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] mask;
    logic [2:0] frame_number_upper_bits;
    logic ack;
    logic [31:0] rdata;
    logic reject;
  } uef_top_st_t;

  // State of the turnaround timer
  typedef struct packed {
    logic armed;
    logic [4:0] cnt;
    logic timeout;
  } uef_tmr_st_t;

endpackage : uef_pkg

// File: design/uef_turn_timer.sv
module uef_turn_timer import uef_pkg::*; #(
  parameter logic [4:0] TURN_BITS = UEF_TURN_BITS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link timing
  input wire logic bit_tick,
  input wire logic eop_done,
  input wire logic rx_start,
  // Result
  output logic timeout
);

  uef_tmr_st_t st_r;
  uef_tmr_st_t st_nxt;

  // Count idle bit times; a response start cancels the wait
  always_comb begin
    st_nxt = st_r;
    st_nxt.timeout = 1'b0;
    if (eop_done) begin
      st_nxt.armed = 1'b1;
      st_nxt.cnt = 5'h00;
    end else if (rx_start) begin
      st_nxt.armed = 1'b0;
    end else if (st_r.armed && bit_tick) begin
      if (st_r.cnt == TURN_BITS) begin
        st_nxt.timeout = 1'b1;
        st_nxt.armed = 1'b0;
      end else begin
        st_nxt.cnt = st_r.cnt + 5'h01;
      end
    end
  end

  // Single register stage for the whole timer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign timeout = st_r.timeout;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_timeout_exact: assert property (st_r.timeout |->
    ($past(st_r.cnt) == TURN_BITS) && $past(bit_tick))
    else $error("Timeout not after the seventeenth idle bit");

  a_no_early: assert property ((st_r.armed && st_r.cnt < TURN_BITS)
    |=> !st_r.timeout)
    else $error("Timeout raised before the limit");

endmodule : uef_turn_timer

// File: design/uef_pid_check.sv
module uef_pid_check import uef_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Received identifier
  input wire logic pid_valid,
  input wire logic [7:0] pid_byte,
  // Result
  output logic pid_err
);

  logic pid_err_r;
  logic pid_err_nxt;

  // Check nibble must be the complement of the type nibble
  always_comb begin
    pid_err_nxt = pid_valid && (pid_byte[7:4] != ~pid_byte[3:0]);
  end

  // Registered one-cycle fault pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pid_err_r <= 1'b0;
    end else begin
      pid_err_r <= pid_err_nxt;
    end
  end

  assign pid_err = pid_err_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_pid_bad: assert property ((pid_valid &&
    (pid_byte[7:4] != ~pid_byte[3:0])) |=> pid_err)
    else $error("Corrupt identifier not flagged");

  a_pid_good: assert property (!pid_valid |=> !pid_err)
    else $error("Identifier fault without a packet");

endmodule : uef_pid_check

// File: design/uef_top.sv
module uef_top import uef_pkg::*; #(
  parameter logic [4:0] TURN_BITS = UEF_TURN_BITS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM register slave
  input wire logic [UEF_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Link engine indications
  input wire uef_evt_t evt,
  input wire logic host_mode,
  input wire logic bit_tick,
  input wire logic eop_done,
  input wire logic rx_start,
  // Received identifier
  input wire logic pid_valid,
  input wire logic [7:0] pid_byte,
  // Start-of-frame token
  input wire logic sof_valid,
  input wire logic [10:0] sof_frame,
  // Results
  output logic pkt_reject,
  output logic irq
);

  uef_top_st_t st_r;
  uef_top_st_t st_nxt;

  logic bto_pulse;
  logic pid_pulse;
  logic req;
  logic wr_take;
  logic rd_prep;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [7:0] wr_low;
  logic [2:0] sof_hi;
  logic data_end;
  logic crc16_fail;

  // Idle time after our end-of-packet
  uef_turn_timer #(
    .TURN_BITS(TURN_BITS)
  ) u_turn (
    .clk(clk),
    .rst_n(rst_n),
    .bit_tick(bit_tick),
    .eop_done(eop_done),
    .rx_start(rx_start),
    .timeout(bto_pulse)
  );

  // Identifier integrity
  uef_pid_check u_pid (
    .clk(clk),
    .rst_n(rst_n),
    .pid_valid(pid_valid),
    .pid_byte(pid_byte),
    .pid_err(pid_pulse)
  );

  // Bus handshake: every access waits exactly one cycle
  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !st_r.ack;
  assign wr_take = avs_write && st_r.ack;
  assign rd_prep = avs_read && !st_r.ack;
  assign wr_low = avs_writedata[7:0];
  assign sof_hi = sof_frame[10:8];

  // Packet-end qualifiers shared by several flags
  assign data_end = evt.rx_end && evt.rx_data_pkt;
  assign crc16_fail = data_end && evt.crc16_bad;

  // Hardware set terms, one per flag
  always_comb begin
    set_vec = 8'h00;
    set_vec[UEF_B_STUFF] = evt.stuff_err;
    set_vec[UEF_B_BMX] = evt.bdt_base_bad || evt.buf_addr_bad;
    set_vec[UEF_B_DMA] = evt.grant_late || evt.buf_trunc;
    set_vec[UEF_B_BTO] = bto_pulse;
    set_vec[UEF_B_DFS] = data_end && (evt.bit_resid != 3'h0);
    set_vec[UEF_B_CRC16] = crc16_fail;
    if (host_mode) begin
      // Frame overrun only matters while the link is moving data
      set_vec[UEF_B_EOF] = evt.sof_zero && evt.link_busy;
    end else begin
      set_vec[UEF_B_EOF] = evt.rx_end && evt.crc5_bad;
    end
    set_vec[UEF_B_PID] = pid_pulse;
  end

  // Write-one-to-clear mask, only on the accepted write beat
  always_comb begin
    clr_vec = 8'h00;
    if (wr_take && avs_address == UEF_OFS_FLAGS) begin
      clr_vec = wr_low;
    end
  end

  // Next-state logic for flags, mask, frame bits and bus
  always_comb begin
    st_nxt = st_r;
    // Set wins over clear so an event in the clear cycle survives
    st_nxt.flags = (st_r.flags & ~clr_vec) | set_vec;
    st_nxt.ack = req && !st_r.ack;
    st_nxt.reject = evt.stuff_err || crc16_fail;
    if (sof_valid) begin
      st_nxt.frame_number_upper_bits = sof_hi;
    end
    if (wr_take && avs_address == UEF_OFS_MASK) begin
      st_nxt.mask = wr_low;
    end
    // Read data is sampled one cycle early and held for the beat
    if (rd_prep) begin
      if (avs_address == UEF_OFS_FLAGS) begin
        st_nxt.rdata = {24'h000000, st_r.flags};
      end else if (avs_address == UEF_OFS_MASK) begin
        st_nxt.rdata = {24'h000000, st_r.mask};
      end else if (avs_address == UEF_OFS_FRAME_NUMBER_UPPER_BITS) begin
        st_nxt.rdata = {29'h0, st_r.frame_number_upper_bits};
      end else begin
        st_nxt.rdata = 32'h00000000;
      end
    end
  end

  // Single register stage for the whole block
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r.flags <= UEF_FLAGS_RST;
      st_r.mask <= UEF_MASK_RST;
      st_r.frame_number_upper_bits <= UEF_FRAME_NUMBER_UPPER_BITS_RST;
      st_r.ack <= 1'b0;
      st_r.rdata <= 32'h00000000;
      st_r.reject <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs; the interrupt is a level from registered state
  assign avs_readdata = st_r.rdata;
  assign pkt_reject = st_r.reject;
  assign irq = |(st_r.flags & st_r.mask);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_w1c_clears: assert property (
    (wr_take && avs_address == UEF_OFS_FLAGS) |=>
    ((st_r.flags & $past(wr_low) & ~$past(set_vec)) == 8'h00))
    else $error("Written one did not clear the flag");

  a_set_wins: assert property ((set_vec != 8'h00) |=>
    ((st_r.flags & $past(set_vec)) == $past(set_vec)))
    else $error("Hardware event lost");

  a_flag_sticky: assert property (
    !(wr_take && avs_address == UEF_OFS_FLAGS) |=>
    ((st_r.flags & $past(st_r.flags)) == $past(st_r.flags)))
    else $error("Flag dropped without a clear");

  a_upper_zero: assert property (
    (avs_read && !avs_waitrequest) |-> avs_readdata[31:8] == 24'h0)
    else $error("Unimplemented bits read nonzero");

  a_wait_one: assert property (
    (req && avs_waitrequest) |=> !avs_waitrequest)
    else $error("Waitrequest held over one cycle");

  a_frame_load: assert property (sof_valid |=>
    st_r.frame_number_upper_bits == $past(sof_hi))
    else $error("Upper frame bits not loaded");

  a_stuff_reject: assert property (evt.stuff_err |=>
    pkt_reject && st_r.flags[UEF_B_STUFF])
    else $error("Stuffing fault not rejected");

  a_crc16_reject: assert property (crc16_fail |=>
    pkt_reject && st_r.flags[UEF_B_CRC16])
    else $error("Data CRC fault not rejected");

  a_eof_host: assert property (
    (host_mode && evt.sof_zero && evt.link_busy) |=>
    st_r.flags[UEF_B_EOF])
    else $error("End-of-frame fault missed");

  a_crc5_dev: assert property (
    (!host_mode && evt.rx_end && evt.crc5_bad) |=>
    st_r.flags[UEF_B_EOF])
    else $error("Token CRC fault missed");

  a_size_flag: assert property (
    (data_end && evt.bit_resid != 3'h0) |=> st_r.flags[UEF_B_DFS])
    else $error("Partial byte not flagged");

  a_dma_flag: assert property (
    (evt.grant_late || evt.buf_trunc) |=> st_r.flags[UEF_B_DMA])
    else $error("DMA fault not flagged");

  a_bmx_flag: assert property (
    (evt.bdt_base_bad || evt.buf_addr_bad) |=> st_r.flags[UEF_B_BMX])
    else $error("Address fault not flagged");

  a_irq_gate: assert property ((st_r.mask == 8'h00) |-> !irq)
    else $error("Interrupt with every source masked");

  // Reset leaves every register at its power-on value
  a_reset_clean: assert property ($rose(rst_n) |->
    (st_r.flags == UEF_FLAGS_RST) && (st_r.mask == UEF_MASK_RST) &&
    (st_r.frame_number_upper_bits == UEF_FRAME_NUMBER_UPPER_BITS_RST) && !irq && !pkt_reject)
    else $error("Registers not cleared by reset");

  // Flags rise only on a hardware event
  a_no_spurious: assert property ((set_vec == 8'h00) |=>
    ((st_r.flags & ~$past(st_r.flags)) == 8'h00))
    else $error("Flag set without an event");

  // Bits written as zero keep their flags
  a_zero_keeps: assert property (
    (wr_take && avs_address == UEF_OFS_FLAGS) |=>
    ((st_r.flags & $past(st_r.flags) & ~$past(wr_low)) ==
    ($past(st_r.flags) & ~$past(wr_low))))
    else $error("Zero write disturbed a flag");

  // One-cycle pulses from the sub-blocks must reach their flags
  a_pid_flag: assert property (
    pid_pulse |=> st_r.flags[UEF_B_PID])
    else $error("Identifier fault not flagged");

  a_bto_flag: assert property (
    bto_pulse |=> st_r.flags[UEF_B_BTO])
    else $error("Turnaround time-out not flagged");

  // A whole-byte data field must not raise the size flag
  a_size_whole: assert property (
    (evt.bit_resid == 3'h0 && !st_r.flags[UEF_B_DFS]) |=>
    !st_r.flags[UEF_B_DFS])
    else $error("Size flag raised for whole bytes");

  // Bit 1 follows only the cause that belongs to the current mode
  a_host_no_crc5: assert property (
    (host_mode && !(evt.sof_zero && evt.link_busy) &&
    !st_r.flags[UEF_B_EOF]) |=> !st_r.flags[UEF_B_EOF])
    else $error("Bit 1 set in host mode without frame overrun");

  a_dev_no_eof: assert property (
    (!host_mode && !(evt.rx_end && evt.crc5_bad) &&
    !st_r.flags[UEF_B_EOF]) |=> !st_r.flags[UEF_B_EOF])
    else $error("Bit 1 set in device mode without token fault");

  // Rejection only follows a stuffing or data CRC fault
  a_reject_cause: assert property (
    (!evt.stuff_err && !crc16_fail) |=> !pkt_reject)
    else $error("Packet rejected without a fault");

  // Mask register takes the written byte and holds it otherwise
  a_mask_write: assert property (
    (wr_take && avs_address == UEF_OFS_MASK) |=>
    (st_r.mask == $past(wr_low)))
    else $error("Mask write lost");

  a_mask_hold: assert property (
    !(wr_take && avs_address == UEF_OFS_MASK) |=> $stable(st_r.mask))
    else $error("Mask changed without a write");

  // Frame bits are read-only; only a start-of-frame token moves them
  a_frame_hold: assert property (
    !sof_valid |=> $stable(st_r.frame_number_upper_bits))
    else $error("Frame bits changed without a token");

  // Read data stands until the next read is prepared
  a_rdata_hold: assert property (
    !rd_prep |=> $stable(avs_readdata))
    else $error("Read data changed outside a read");

  a_rd_flags: assert property (
    (rd_prep && avs_address == UEF_OFS_FLAGS) |=>
    (avs_readdata == {24'h000000, $past(st_r.flags)}))
    else $error("Flag read returned a wrong word");

  a_rd_frame: assert property (
    (rd_prep && avs_address == UEF_OFS_FRAME_NUMBER_UPPER_BITS) |=>
    (avs_readdata == {29'h0, $past(st_r.frame_number_upper_bits)}))
    else $error("Frame bits read back wrong");

  // Holes in the map read as zero, so software sees no stale data
  a_rd_unmapped: assert property (
    (rd_prep && avs_address != UEF_OFS_FLAGS &&
    avs_address != UEF_OFS_MASK && avs_address != UEF_OFS_FRAME_NUMBER_UPPER_BITS) |=>
    (avs_readdata == 32'h00000000))
    else $error("Unmapped read not zero");

  // An unmasked event must raise the interrupt one cycle later
  a_irq_raise: assert property (
    (((set_vec & st_r.mask) != 8'h00) &&
    !(wr_take && avs_address == UEF_OFS_MASK)) |=> irq)
    else $error("Unmasked event did not interrupt");

endmodule : uef_top

// File: sim/uef_peer_model.sv
module uef_peer_model import uef_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Turnaround request and reply delay in bit times, 0 = silent
  input wire logic eop_done,
  input wire logic [3:0] resp_bits,
  // Bus timing seen by the block
  output logic bit_tick,
  output logic rx_start
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_r;
  logic [3:0] cnt_r;
  logic wait_r;

  // One bit time every three clocks; the real bus rate is unrelated
  assign bit_tick = (div_r == 2'h2);

  // Reply after the chosen number of bit times, or never
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_r <= 2'h0;
      cnt_r <= 4'h0;
      wait_r <= 1'b0;
      rx_start <= 1'b0;
    end else begin
      div_r <= bit_tick ? 2'h0 : div_r + 2'h1;
      rx_start <= 1'b0;
      if (eop_done) begin
        wait_r <= 1'b1;
        cnt_r <= 4'h0;
      end else if (wait_r && bit_tick) begin
        cnt_r <= cnt_r + 4'h1;
        // A zero delay means no reply, even when the count wraps
        if (resp_bits != 4'h0 && cnt_r + 4'h1 == resp_bits) begin
          rx_start <= 1'b1;
          wait_r <= 1'b0;
        end
      end
    end
  end
endmodule : uef_peer_model

// File: sim/uef_top_bench.sv
module uef_top_bench import uef_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, host_mode;
  logic [3:0] avs_address, resp_bits;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic bit_tick, eop_done, rx_start, pid_valid, sof_valid;
  logic pkt_reject, irq;
  logic [7:0] pid_byte;
  logic [10:0] sof_frame;
  uef_evt_t evt;
  int bad_count, num_checks, cyc;
  // Flags expected after each entry of the event table
  logic [7:0] ex_tab [9] = '{8'h80, 8'h40, 8'h40, 8'h20, 8'h20, 8'h08,
    8'h04, 8'h02, 8'h00};

  // Short turnaround limit keeps the timer scenario brief
  uef_top #(.TURN_BITS(5'h04)) dut (.clk, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .evt,
    .host_mode, .bit_tick, .eop_done, .rx_start, .pid_valid, .pid_byte,
    .sof_valid, .sof_frame, .pkt_reject, .irq);
  uef_peer_model peer (.clk, .rst_n, .eop_done, .resp_bits, .bit_tick,
    .rx_start);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // A hang counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      final_report();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Request held until waitrequest is sampled low at a rising edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd

  task pulse(input uef_evt_t e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= '0;
  endtask : pulse

  task t_reset;
    rd(UEF_OFS_FLAGS, 32'h0);
    rd(UEF_OFS_MASK, 32'h0);
    rd(UEF_OFS_FRAME_NUMBER_UPPER_BITS, 32'h0);
    bus(1'b1, 4'hc, 32'hff);
    rd(4'hc, 32'h0);
    $display("reset test done");
  endtask : t_reset

  task t_flags;
    uef_evt_t e;
    for (int b = 0; b < 9; b++) begin
      e = '0;
      case (b)
        0: e.stuff_err = 1'b1;
        1: e.bdt_base_bad = 1'b1;
        2: e.buf_addr_bad = 1'b1;
        3: e.grant_late = 1'b1;
        4: e.buf_trunc = 1'b1;
        default: begin
          e.rx_end = 1'b1;
          e.rx_data_pkt = (b != 7);
          e.bit_resid = (b == 5) ? 3'h5 : 3'h0;
          e.crc16_bad = (b == 6);
          e.crc5_bad = (b == 7);
        end
      endcase
      pulse(e);
      @(negedge clk);
      chk(32'(pkt_reject), 32'(b == 0 || b == 6));
      rd(UEF_OFS_FLAGS, {24'h0, ex_tab[b]});
      bus(1'b1, UEF_OFS_FLAGS, 32'h0);
      rd(UEF_OFS_FLAGS, {24'h0, ex_tab[b]});
      bus(1'b1, UEF_OFS_FLAGS, 32'hffff_ffff);
      rd(UEF_OFS_FLAGS, 32'h0);
    end
    $display("flag test done");
  endtask : t_flags

  task t_irq;
    pulse(14'h2000);
    @(negedge clk);
    chk(32'(irq), 32'h0);
    bus(1'b1, UEF_OFS_MASK, 32'h80);
    rd(UEF_OFS_MASK, 32'h80);
    chk(32'(irq), 32'h1);
    bus(1'b1, UEF_OFS_FLAGS, 32'h80);
    @(negedge clk);
    chk(32'(irq), 32'h0);
    bus(1'b1, UEF_OFS_MASK, 32'h0);
    $display("interrupt test done");
  endtask : t_irq

  // Peer replies within three bit times, then stays silent
  task t_turn;
    for (int s = 0; s < 2; s++) begin
      resp_bits <= (s == 0) ? 4'h3 : 4'h0;
      @(posedge clk);
      eop_done <= 1'b1;
      @(posedge clk);
      eop_done <= 1'b0;
      repeat (30) @(posedge clk); // Ten bit times
      rd(UEF_OFS_FLAGS, (s == 0) ? 32'h0 : 32'h10);
    end
    bus(1'b1, UEF_OFS_FLAGS, 32'h10);
    $display("turnaround test done");
  endtask : t_turn

  task t_pid_sof;
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      pid_valid <= 1'b1;
      pid_byte <= (s == 0) ? 8'he1 : 8'h11;
      sof_valid <= 1'b1;
      sof_frame <= (s == 0) ? 11'h5a5 : 11'h2ff;
      @(posedge clk);
      pid_valid <= 1'b0;
      sof_valid <= 1'b0;
      repeat (2) @(posedge clk);
      rd(UEF_OFS_FLAGS, 32'(s));
      rd(UEF_OFS_FRAME_NUMBER_UPPER_BITS, (s == 0) ? 32'h5 : 32'h2);
      bus(1'b1, UEF_OFS_FRAME_NUMBER_UPPER_BITS, 32'h7);
      rd(UEF_OFS_FRAME_NUMBER_UPPER_BITS, (s == 0) ? 32'h5 : 32'h2);
    end
    bus(1'b1, UEF_OFS_FLAGS, 32'h1);
    $display("identifier and frame test done");
  endtask : t_pid_sof

  // Reset in mid-run must return every register to zero
  task t_rerst;
    pulse(14'h2000);
    bus(1'b1, UEF_OFS_MASK, 32'h80);
    @(posedge clk);
    sof_valid <= 1'b1;
    sof_frame <= 11'h7ff;
    @(negedge clk);
    chk(32'(irq), 32'h1);
    @(posedge clk);
    sof_valid <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(32'(irq), 32'h0);
    rd(UEF_OFS_FLAGS, 32'h0);
    rd(UEF_OFS_MASK, 32'h0);
    rd(UEF_OFS_FRAME_NUMBER_UPPER_BITS, 32'h0);
    $display("mid-run reset test done");
  endtask : t_rerst

  // In host mode bit 1 ignores token CRC and tracks the frame counter
  task t_host;
    host_mode <= 1'b1;
    pulse(14'h0120);
    rd(UEF_OFS_FLAGS, 32'h0);
    pulse(14'h0003);
    rd(UEF_OFS_FLAGS, 32'h2);
    bus(1'b1, UEF_OFS_FLAGS, 32'h2);
    rd(UEF_OFS_FLAGS, 32'h0);
    host_mode <= 1'b0;
    $display("host mode test done");
  endtask : t_host

  task final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  initial begin
    {rst_n, avs_read, avs_write, host_mode, eop_done} = '0;
    {pid_valid, sof_valid, avs_address, resp_bits} = '0;
    {avs_writedata, pid_byte, sof_frame, evt} = '0;
    {bad_count, num_checks, cyc} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_flags();
    t_irq();
    t_turn();
    t_pid_sof();
    t_rerst();
    t_host();
    final_report();
  end
endmodule : uef_top_bench
